// ---- include/timer_link_pkg.sv ----
// Constants for the sync input and timer routing block.
// Assumes an 8-bit register port with 16-bit byte addresses.
package timer_link_pkg;

	// ************************************************
	// Register addresses
	// ************************************************
	localparam logic [15:0] ADDR_STOP_HI  = 16'hFF86;
	localparam logic [15:0] ADDR_STOP_LO  = 16'hFF87;
	localparam logic [15:0] ADDR_IN_CTL   = 16'hFFFC;
	localparam logic [15:0] ADDR_OUT_CTL  = 16'hFFFD;
	localparam logic [15:0] ADDR_SRC_SEL  = 16'hFFFE;
	localparam logic [15:0] ADDR_EDGE     = 16'hFFFF;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'hFFE0;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'hFFE1;
	localparam logic [15:0] ADDR_RISE_CAP = 16'hFFE2;
	localparam logic [15:0] ADDR_FALL_CAP = 16'hFFE3;

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [7:0] RST_STOP_HI = 8'h3F;
	localparam logic [7:0] RST_STOP_LO = 8'hFF;
	localparam logic [7:0] RST_ZERO    = 8'h00;

	// ************************************************
	// Input control fields
	// ************************************************
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int CONN_EN = 5;
	localparam int ARM     = 4;
	localparam int SH_INV  = 3;
	localparam int SV_INV  = 2;
	localparam int HC_INV  = 1;
	localparam int V_INV   = 0;

	localparam logic [1:0] MODE_SPARE = 2'h0;
	localparam logic [1:0] MODE_SONG  = 2'h1;
	localparam logic [1:0] MODE_COMP  = 2'h2;
	localparam logic [1:0] MODE_SEP   = 2'h3;

	// Edge flag bank, interrupt status layout, pin count and capture states
	localparam int EDGE_FLAGS = 6;
	localparam int IRQ_EDGE   = 0;
	localparam int IRQ_CAP    = 1;
	localparam int PIN_COUNT  = 11;

	typedef enum logic [2:0] {
		CAP_IDLE      = 3'h1,
		CAP_WAIT_RISE = 3'h2,
		CAP_WAIT_FALL = 3'h4
	} cap_state_t;

endpackage

// ---- hdl/pin_sync.sv ----
// Two-stage synchroniser for asynchronous pin levels.
// Assumes every bit is an independent level from outside the clock domain.
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 11
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_reg <= '0;
			sync_o   <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end
endmodule // pin_sync

// ---- hdl/edge_sense_bank.sv ----
// Sticky rising-edge flags, cleared by reset or by writing zero.
// Assumes inputs are already synchronised to clk_i.
`timescale 1ns/100ps
module edge_sense_bank (
	input  wire logic                                clk_i,
	input  wire logic                                sys_rst_i,
	input  wire logic [timer_link_pkg::EDGE_FLAGS-1:0] sig_i,
	input  wire logic                                clr_i,
	input  wire logic [timer_link_pkg::EDGE_FLAGS-1:0] wdata_i,
	output logic      [timer_link_pkg::EDGE_FLAGS-1:0] flags_o,
	output logic                                     set_o
);
	logic [timer_link_pkg::EDGE_FLAGS-1:0] prev_reg;
	logic [timer_link_pkg::EDGE_FLAGS-1:0] rise;

	// Tracks the input during reset too, so an idle-high input gives no false edge
	always_ff @(posedge clk_i) begin
		prev_reg <= sig_i;
	end

	genvar i;
	generate
		for (i = 0; i < timer_link_pkg::EDGE_FLAGS; i++) begin : g_flag
			assign rise[i] = sig_i[i] & ~prev_reg[i];
			// Set beats a same-cycle clear; writing one leaves the flag
			always_ff @(posedge clk_i) begin
				if (sys_rst_i)
					flags_o[i] <= 1'b0;
				else if (rise[i])
					flags_o[i] <= 1'b1;
				else if (clr_i && !wdata_i[i])
					flags_o[i] <= 1'b0;
			end
		end
	endgenerate

	assign set_o = |rise;
endmodule // edge_sense_bank

// ---- hdl/sync_input_timer_routing.sv ----
// Sync input selection, timer input routing and one-shot pulse capture.
// Assumes pins are asynchronous; timer signals and standby share clk_i.
//
// Functional notes
// - Registers reachable only while host port enable is zero.
// - Input control register clears on reset and during hardware standby.
// - Edge flag bits 7..2 cleared by writing zero; writing one ignored.
// - Edge register bits 1..0 read current input states.
// - Mode field picks internal hsync and vsync sources.
// - Connect enable zero: timer inputs come from their own pins.
// - Connect enable one: timer inputs rerouted to sync signals, except capture b, which takes timer one compare out.
// - Capture timer reset input follows internal hsync.
// - Armed: count captured on rising edge, then on next falling edge.
// - Arm bit clears itself after the edge pair is captured.
// - Arm bit sets only on writing one after reading it zero.
// - Arm zero stops both captures; zero after reset.
// - Bit 3 inverts the spare hsync pin.
// - Bit 2 inverts the spare vsync pin.
// - Bit 1 inverts hsync and composite sync pins.
// - Bit 0 inverts the vsync pin.
// - Internal signals are positive logic after inversion.
`timescale 1ns/100ps
module sync_input_timer_routing (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       standby_i,
	input  wire logic       host_port_enable_bit_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       hsync_pin_i,
	input  wire logic       vsync_pin_i,
	input  wire logic       composite_sync_pin_i,
	input  wire logic       spare_hsync_pin_i,
	input  wire logic       spare_vsync_pin_i,
	input  wire logic       freerun_capture_a_pin_i,
	input  wire logic       freerun_capture_b_pin_i,
	input  wire logic       freerun_capture_c_pin_i,
	input  wire logic       freerun_capture_d_pin_i,
	input  wire logic       timer_one_clock_pin_i,
	input  wire logic       timer_one_reset_pin_i,
	input  wire logic       vertical_separator_signal_i,
	input  wire logic       timer_one_compare_out_i,
	input  wire logic [7:0] capture_timer_count_i,
	output logic            internal_hsync_in_o,
	output logic            internal_vsync_in_o,
	output logic            freerun_capture_a_o,
	output logic            freerun_capture_b_o,
	output logic            freerun_capture_c_o,
	output logic            freerun_capture_d_o,
	output logic            timer_one_clock_in_o,
	output logic            timer_one_reset_in_o,
	output logic            capture_timer_reset_in_o,
	output logic      [7:0] rise_capture_o,
	output logic      [7:0] fall_capture_o,
	output logic      [7:0] output_control_o,
	output logic      [7:0] source_select_o,
	output logic      [7:0] module_stop_high_o,
	output logic      [7:0] module_stop_low_o,
	output logic            irq_o
);
	// ************************************************
	// Declarations
	// ************************************************
	logic [timer_link_pkg::PIN_COUNT-1:0]  pins_async;
	logic [timer_link_pkg::PIN_COUNT-1:0]  pins;
	logic [7:0]                           in_ctl_reg;
	logic                                 seen_zero_reg;
	logic [1:0]                           irq_stat_reg;
	logic [1:0]                           irq_mask_reg;
	logic [7:0]                           rise_pend_reg;
	logic                                 rst_in_prev_reg;
	timer_link_pkg::cap_state_t           cap_state_reg;
	timer_link_pkg::cap_state_t           cap_state_next;
	logic                                 access_ok;
	logic                                 wr_ok;
	logic                                 rd_ok;
	logic                                 wr_in_ctl;
	logic                                 arm_set;
	logic                                 cap_rise;
	logic                                 cap_fall;
	logic                                 cap_done;
	logic                                 hs_in;
	logic                                 vs_in;
	logic                                 cs_in;
	logic                                 sh_in;
	logic                                 sv_in;
	logic                                 int_hsync;
	logic                                 int_vsync;
	logic [1:0]                           mode;
	logic [timer_link_pkg::EDGE_FLAGS-1:0] edge_flags;
	logic                                 edge_set;
	logic [7:0]                           rd_mux;

	// ************************************************
	// Pin synchronisers
	// ************************************************
	assign pins_async = {timer_one_reset_pin_i, timer_one_clock_pin_i,
		freerun_capture_d_pin_i, freerun_capture_c_pin_i,
		freerun_capture_b_pin_i, freerun_capture_a_pin_i,
		spare_vsync_pin_i, spare_hsync_pin_i,
		composite_sync_pin_i, vsync_pin_i, hsync_pin_i};

	pin_sync #(.WIDTH(timer_link_pkg::PIN_COUNT)) u_pin_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (pins_async),
		.sync_o    (pins)
	);

	// ************************************************
	// Input inversion and source selection
	// ************************************************
	assign sh_in = pins[3] ^ in_ctl_reg[timer_link_pkg::SH_INV];
	assign sv_in = pins[4] ^ in_ctl_reg[timer_link_pkg::SV_INV];
	assign hs_in = pins[0] ^ in_ctl_reg[timer_link_pkg::HC_INV];
	assign cs_in = pins[2] ^ in_ctl_reg[timer_link_pkg::HC_INV];
	assign vs_in = pins[1] ^ in_ctl_reg[timer_link_pkg::V_INV];
	assign mode  = in_ctl_reg[timer_link_pkg::MODE_HI:timer_link_pkg::MODE_LO];

	always_comb begin
		case (mode)
			timer_link_pkg::MODE_SPARE: begin
				int_hsync = sh_in;
				int_vsync = sv_in;
			end
			timer_link_pkg::MODE_SONG: begin
				int_hsync = cs_in;
				int_vsync = vertical_separator_signal_i;
			end
			timer_link_pkg::MODE_COMP: begin
				int_hsync = hs_in;
				int_vsync = vertical_separator_signal_i;
			end
			default: begin
				int_hsync = hs_in;
				int_vsync = vs_in;
			end
		endcase
	end

	// ************************************************
	// Timer input routing
	// ************************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			internal_hsync_in_o      <= 1'b0;
			internal_vsync_in_o      <= 1'b0;
			capture_timer_reset_in_o <= 1'b0;
			freerun_capture_a_o      <= 1'b0;
			freerun_capture_b_o      <= 1'b0;
			freerun_capture_c_o      <= 1'b0;
			freerun_capture_d_o      <= 1'b0;
			timer_one_clock_in_o     <= 1'b0;
			timer_one_reset_in_o     <= 1'b0;
		end else begin
			internal_hsync_in_o      <= int_hsync;
			internal_vsync_in_o      <= int_vsync;
			capture_timer_reset_in_o <= int_hsync;
			if (in_ctl_reg[timer_link_pkg::CONN_EN]) begin
				freerun_capture_a_o  <= int_vsync;
				freerun_capture_b_o  <= timer_one_compare_out_i;
				freerun_capture_c_o  <= sv_in;
				freerun_capture_d_o  <= int_hsync;
				timer_one_clock_in_o <= int_hsync;
				timer_one_reset_in_o <= ~int_vsync;
			end else begin
				freerun_capture_a_o  <= pins[5];
				freerun_capture_b_o  <= pins[6];
				freerun_capture_c_o  <= pins[7];
				freerun_capture_d_o  <= pins[8];
				timer_one_clock_in_o <= pins[9];
				timer_one_reset_in_o <= pins[10];
			end
		end
	end

	// ************************************************
	// Register port
	// ************************************************
	assign access_ok = ~host_port_enable_bit_i;
	assign wr_ok     = wr_i & access_ok;
	assign rd_ok     = rd_i & access_ok;
	assign wr_in_ctl = wr_ok && (addr_i == timer_link_pkg::ADDR_IN_CTL);
	assign arm_set   = wr_in_ctl && wdata_i[timer_link_pkg::ARM] && seen_zero_reg;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || standby_i) begin
			in_ctl_reg <= timer_link_pkg::RST_ZERO;
		end else begin
			if (wr_in_ctl) begin
				in_ctl_reg[7:5] <= wdata_i[7:5];
				in_ctl_reg[3:0] <= wdata_i[3:0];
			end
			if (arm_set)
				in_ctl_reg[timer_link_pkg::ARM] <= 1'b1;
			else if (wr_in_ctl && !wdata_i[timer_link_pkg::ARM])
				in_ctl_reg[timer_link_pkg::ARM] <= 1'b0;
			else if (cap_done)
				in_ctl_reg[timer_link_pkg::ARM] <= 1'b0;
		end
	end

	// Remembers that software saw the arm bit at zero
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || standby_i)
			seen_zero_reg <= 1'b0;
		else if (wr_in_ctl)
			seen_zero_reg <= 1'b0;
		else if (rd_ok && addr_i == timer_link_pkg::ADDR_IN_CTL)
			seen_zero_reg <= ~in_ctl_reg[timer_link_pkg::ARM];
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || standby_i) begin
			output_control_o <= timer_link_pkg::RST_ZERO;
			source_select_o  <= timer_link_pkg::RST_ZERO;
		end else if (wr_ok) begin
			if (addr_i == timer_link_pkg::ADDR_OUT_CTL)
				output_control_o <= wdata_i;
			if (addr_i == timer_link_pkg::ADDR_SRC_SEL)
				source_select_o <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			module_stop_high_o <= timer_link_pkg::RST_STOP_HI;
			module_stop_low_o  <= timer_link_pkg::RST_STOP_LO;
		end else if (wr_ok) begin
			if (addr_i == timer_link_pkg::ADDR_STOP_HI)
				module_stop_high_o <= wdata_i;
			if (addr_i == timer_link_pkg::ADDR_STOP_LO)
				module_stop_low_o <= wdata_i;
		end
	end

	always_comb begin
		case (addr_i)
			timer_link_pkg::ADDR_IN_CTL:   rd_mux = in_ctl_reg;
			timer_link_pkg::ADDR_OUT_CTL:  rd_mux = output_control_o;
			timer_link_pkg::ADDR_SRC_SEL:  rd_mux = source_select_o;
			timer_link_pkg::ADDR_EDGE:     rd_mux = {edge_flags, int_hsync, int_vsync};
			timer_link_pkg::ADDR_STOP_HI:  rd_mux = module_stop_high_o;
			timer_link_pkg::ADDR_STOP_LO:  rd_mux = module_stop_low_o;
			timer_link_pkg::ADDR_IRQ_STAT: rd_mux = {6'h00, irq_stat_reg};
			timer_link_pkg::ADDR_IRQ_MASK: rd_mux = {6'h00, irq_mask_reg};
			timer_link_pkg::ADDR_RISE_CAP: rd_mux = rise_capture_o;
			timer_link_pkg::ADDR_FALL_CAP: rd_mux = fall_capture_o;
			default:                       rd_mux = 8'h00;
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			rdata_o <= 8'h00;
		else if (rd_ok)
			rdata_o <= rd_mux;
		else
			rdata_o <= 8'h00;
	end

	// ************************************************
	// Edge sense flags
	// ************************************************
	edge_sense_bank u_edge (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.sig_i     ({sh_in, sv_in, hs_in, vs_in, cs_in, vertical_separator_signal_i}),
		.clr_i     (wr_ok && addr_i == timer_link_pkg::ADDR_EDGE),
		.wdata_i   (wdata_i[7:2]),
		.flags_o   (edge_flags),
		.set_o     (edge_set)
	);

	// ************************************************
	// One-shot pulse width capture
	// ************************************************
	assign cap_rise = capture_timer_reset_in_o & ~rst_in_prev_reg;
	assign cap_fall = ~capture_timer_reset_in_o & rst_in_prev_reg;
	// A disarming write in the completing cycle wins: no capture update
	assign cap_done = (cap_state_reg == timer_link_pkg::CAP_WAIT_FALL) && cap_fall
		&& in_ctl_reg[timer_link_pkg::ARM]
		&& !(wr_in_ctl && !wdata_i[timer_link_pkg::ARM]);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			rst_in_prev_reg <= 1'b0;
		else
			rst_in_prev_reg <= capture_timer_reset_in_o;
	end

	always_comb begin
		cap_state_next = cap_state_reg;
		case (cap_state_reg)
			timer_link_pkg::CAP_IDLE:
				if (in_ctl_reg[timer_link_pkg::ARM])
					cap_state_next = timer_link_pkg::CAP_WAIT_RISE;
			timer_link_pkg::CAP_WAIT_RISE:
				if (!in_ctl_reg[timer_link_pkg::ARM])
					cap_state_next = timer_link_pkg::CAP_IDLE;
				else if (cap_rise)
					cap_state_next = timer_link_pkg::CAP_WAIT_FALL;
			timer_link_pkg::CAP_WAIT_FALL:
				if (!in_ctl_reg[timer_link_pkg::ARM] || cap_fall)
					cap_state_next = timer_link_pkg::CAP_IDLE;
			default:
				cap_state_next = timer_link_pkg::CAP_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || standby_i)
			cap_state_reg <= timer_link_pkg::CAP_IDLE;
		else
			cap_state_reg <= cap_state_next;
	end

	// Rising count is held back until the pair completes
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rise_pend_reg  <= 8'h00;
			rise_capture_o <= 8'h00;
			fall_capture_o <= 8'h00;
		end else begin
			if (cap_state_reg == timer_link_pkg::CAP_WAIT_RISE && cap_rise
				&& in_ctl_reg[timer_link_pkg::ARM])
				rise_pend_reg <= capture_timer_count_i;
			if (cap_done) begin
				rise_capture_o <= rise_pend_reg;
				fall_capture_o <= capture_timer_count_i;
			end
		end
	end

	// ************************************************
	// Interrupts
	// ************************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_stat_reg <= 2'h0;
			irq_mask_reg <= 2'h0;
		end else begin
			if (wr_ok && addr_i == timer_link_pkg::ADDR_IRQ_MASK)
				irq_mask_reg <= wdata_i[1:0];
			if (wr_ok && addr_i == timer_link_pkg::ADDR_IRQ_STAT)
				irq_stat_reg <= (irq_stat_reg & ~wdata_i[1:0])
					| {cap_done, edge_set};
			else
				irq_stat_reg <= irq_stat_reg | {cap_done, edge_set};
		end
	end

	assign irq_o = |(irq_stat_reg & irq_mask_reg);

	// ************************************************
	// Assertions
	// ************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_blocked_write_ignored:
		assert property (wr_i && host_port_enable_bit_i && addr_i == timer_link_pkg::ADDR_IN_CTL
			&& !cap_done |=> $stable(in_ctl_reg))
		else $error("write landed while access blocked");
	a_blocked_read_zero:
		assert property (rd_i && host_port_enable_bit_i |=> rdata_o == 8'h00)
		else $error("blocked read returned data");
	a_standby_clears_ctl:
		assert property (standby_i |=> in_ctl_reg == 8'h00)
		else $error("input control not cleared in standby");
	a_edge_one_no_clear:
		assert property (edge_flags[5] && wr_ok && addr_i == timer_link_pkg::ADDR_EDGE
			&& wdata_i[7] |=> edge_flags[5])
		else $error("writing one cleared an edge flag");
	a_edge_pin_readback:
		assert property (rd_ok && addr_i == timer_link_pkg::ADDR_EDGE
			|=> rdata_o[1:0] == $past({int_hsync, int_vsync}))
		else $error("edge register low bits wrong");
	a_separate_mode_route:
		assert property (mode == timer_link_pkg::MODE_SEP
			|=> internal_vsync_in_o == $past(vs_in))
		else $error("separate mode vsync source wrong");
	a_normal_connect:
		assert property (!in_ctl_reg[timer_link_pkg::CONN_EN]
			|=> freerun_capture_d_o == $past(pins[8]))
		else $error("capture d not from its pin");
	a_sync_connect:
		assert property (in_ctl_reg[timer_link_pkg::CONN_EN]
			|=> timer_one_reset_in_o == !internal_vsync_in_o)
		else $error("timer one reset not inverted vsync");
	a_reset_follows_ihi:
		assert property (capture_timer_reset_in_o == internal_hsync_in_o)
		else $error("capture timer reset not internal hsync");
	a_pair_capture:
		assert property (cap_done |=> fall_capture_o == $past(capture_timer_count_i)
			&& !in_ctl_reg[timer_link_pkg::ARM])
		else $error("fall capture or arm clear failed");
	a_arm_self_clear:
		assert property (cap_done && !arm_set |=> cap_state_reg == timer_link_pkg::CAP_IDLE
			##1 cap_state_reg == timer_link_pkg::CAP_IDLE)
		else $error("capture did not stop after pair");
	a_arm_needs_read:
		assert property (wr_in_ctl && !seen_zero_reg && !in_ctl_reg[timer_link_pkg::ARM]
			|=> !in_ctl_reg[timer_link_pkg::ARM])
		else $error("arm set without prior zero read");
	a_disarmed_idle:
		assert property (!in_ctl_reg[timer_link_pkg::ARM] && !$past(in_ctl_reg[timer_link_pkg::ARM])
			|-> cap_state_reg == timer_link_pkg::CAP_IDLE)
		else $error("capture running while disarmed");
	a_abandon_no_update:
		assert property (wr_in_ctl && !wdata_i[timer_link_pkg::ARM]
			|=> $stable(rise_capture_o) [*2])
		else $error("abandoned capture updated register");

	c_pair_done:    cover property (cap_done);
	c_sync_mode:    cover property (in_ctl_reg[timer_link_pkg::CONN_EN] && mode == 2'h1);
	c_edge_irq:     cover property (irq_o && irq_stat_reg[timer_link_pkg::IRQ_EDGE]);
	c_abandon_wait: cover property (cap_state_reg == timer_link_pkg::CAP_WAIT_FALL
		##1 cap_state_reg == timer_link_pkg::CAP_IDLE && !$past(cap_done));
endmodule // sync_input_timer_routing

// ---- hdl/_unused_placeholder_none.sv ----
// Intentionally empty: no further design content.
`timescale 1ns/100ps

// ---- sim/sync_source_model.sv ----
// Far-side model: sync pulse source and free-running capture timer count.
// Assumes one clock shared with the block under test.
`timescale 1ns/100ps
module sync_source_model (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       start_i,
	input  wire logic [7:0] width_i,
	output logic      [7:0] count_o,
	output logic            hsync_o
);
	logic [7:0] left_reg;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			count_o <= 8'h00;
			left_reg <= 8'h00;
		end else begin
			count_o <= count_o + 8'h01;
			left_reg <= start_i ? width_i : left_reg - {7'h00, |left_reg};
		end
	end
	// Pulse stays high for exactly width_i cycles
	assign hsync_o = |left_reg;
endmodule // sync_source_model

// ---- sim/test_sync_input_timer_routing.sv ----
// Self-checking bench for the sync input and timer routing block.
// Assumes the far-side model sync_source_model and a 50 MHz clock.
`timescale 1ns/100ps
module test_sync_input_timer_routing;
	logic        clk_i = 1'b0, sys_rst_i = 1'b1, stby = 1'b0, hpe = 1'b0;
	logic        wr = 1'b0, rd = 1'b0, start = 1'b0, sh = 1'b1, sv = 1'b0;
	logic        cs = 1'b1, vs = 1'b1, vsep = 1'b1, cmp = 1'b1, ih, iv, ctr, irq, hs;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wd = 8'h00, width = 8'h00, rdata, rise, fall, cnt, d;
	logic [5:0]  fp = 6'b001011;
	wire  [5:0]  fo;
	int          n_fail = 0, samples_checked = 0;

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	sync_input_timer_routing sync_input_timer_routing_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .standby_i(stby),
		.host_port_enable_bit_i(hpe), .addr_i(addr), .wdata_i(wd), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .hsync_pin_i(hs), .vsync_pin_i(vs),
		.composite_sync_pin_i(cs), .spare_hsync_pin_i(sh), .spare_vsync_pin_i(sv),
		.freerun_capture_a_pin_i(fp[5]), .freerun_capture_b_pin_i(fp[4]),
		.freerun_capture_c_pin_i(fp[3]), .freerun_capture_d_pin_i(fp[2]),
		.timer_one_clock_pin_i(fp[1]), .timer_one_reset_pin_i(fp[0]),
		.vertical_separator_signal_i(vsep), .timer_one_compare_out_i(cmp),
		.capture_timer_count_i(cnt), .internal_hsync_in_o(ih), .internal_vsync_in_o(iv),
		.freerun_capture_a_o(fo[5]), .freerun_capture_b_o(fo[4]),
		.freerun_capture_c_o(fo[3]), .freerun_capture_d_o(fo[2]),
		.timer_one_clock_in_o(fo[1]), .timer_one_reset_in_o(fo[0]),
		.capture_timer_reset_in_o(ctr), .rise_capture_o(rise), .fall_capture_o(fall),
		.output_control_o(), .source_select_o(), .module_stop_high_o(),
		.module_stop_low_o(), .irq_o(irq)
	);

	sync_source_model sync_source_model_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start), .width_i(width),
		.count_o(cnt), .hsync_o(hs)
	);

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wreg(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rreg(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic wic(input logic [7:0] v);
		wreg(timer_link_pkg::ADDR_IN_CTL, v);
	endtask

	task automatic ric(output logic [7:0] v);
		rreg(timer_link_pkg::ADDR_IN_CTL, v);
	endtask

	// Sync pulse on the hsync pin, then time for sync and capture to settle
	task automatic pulse(input logic [7:0] w);
		@(posedge clk_i);
		width <= w;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		repeat (w + 8) @(posedge clk_i);
	endtask

	task automatic t_regs();
		rreg(timer_link_pkg::ADDR_STOP_HI, d);
		chk("stop_hi", timer_link_pkg::RST_STOP_HI, d);
		rreg(timer_link_pkg::ADDR_STOP_LO, d);
		chk("stop_lo", timer_link_pkg::RST_STOP_LO, d);
		ric(d);
		chk("in_ctl reset", 8'h00, d);
		rreg(16'h1234, d);
		chk("unmapped", 8'h00, d);
		hpe <= 1'b1;
		wic(8'h0C);
		ric(d);
		chk("blocked read", 8'h00, d);
		hpe <= 1'b0;
		ric(d);
		chk("blocked write", 8'h00, d);
		wic(8'hEF);
		stby <= 1'b1;
		@(posedge clk_i);
		stby <= 1'b0;
		ric(d);
		chk("standby", 8'h00, d);
	endtask

	task automatic t_route();
		logic h, v, x;
		for (int k = 0; k < 8; k++) begin
			x = k[2];
			wic({k[1:0], 2'b00, {4{x}}});
			h = (k[1:0] == 2'd0) ? sh ^ x : (k[1:0] == 2'd1) ? cs ^ x : hs ^ x;
			v = (k[1:0] == 2'd0) ? sv ^ x : (k[1:0] == 2'd3) ? vs ^ x : vsep;
			repeat (5) @(posedge clk_i);
			chk("sync", {5'h00, h, v, h}, {5'h00, ih, iv, ctr});
			rreg(timer_link_pkg::ADDR_EDGE, d);
			chk("edge pins", {6'h00, h, v}, {6'h00, d[1:0]});
		end
	endtask

	task automatic t_connect();
		wic(8'hC0);
		repeat (5) @(posedge clk_i);
		chk("normal", {2'b00, fp}, {2'b00, fo});
		wic(8'hE0);
		repeat (5) @(posedge clk_i);
		chk("linked", 8'h30, {2'b00, fo});
	endtask

	task automatic t_edge();
		wreg(timer_link_pkg::ADDR_EDGE, 8'hFF);
		rreg(timer_link_pkg::ADDR_EDGE, d);
		chk("flag keep", 8'h80, {d[7], 7'h00});
		wreg(timer_link_pkg::ADDR_EDGE, 8'h00);
		rreg(timer_link_pkg::ADDR_EDGE, d);
		chk("flag clear", 8'h00, {d[7:2], 2'b00});
		wreg(timer_link_pkg::ADDR_IRQ_MASK, 8'h01);
		chk("edge irq", 8'h01, {7'h00, irq});
		wreg(timer_link_pkg::ADDR_IRQ_STAT, 8'h01);
		chk("edge irq clr", 8'h00, {7'h00, irq});
	endtask

	task automatic t_capture();
		wic(8'hF0);
		pulse(8'h09);
		ric(d);
		chk("arm no read", 8'h00, {3'h0, d[4], 4'h0});
		chk("stopped", 8'h00, fall);
		wic(8'hF0);
		ric(d);
		chk("armed", 8'h10, {3'h0, d[4], 4'h0});
		wreg(timer_link_pkg::ADDR_IRQ_MASK, 8'h02);
		pulse(8'h09);
		chk("width", 8'h09, fall - rise);
		chk("cap irq", 8'h01, {7'h00, irq});
		ric(d);
		chk("arm clear", 8'h00, {3'h0, d[4], 4'h0});
		wreg(timer_link_pkg::ADDR_IRQ_STAT, 8'h02);
		chk("cap irq clr", 8'h00, {7'h00, irq});
		wic(8'hF0);
		wic(8'hE0);
		pulse(8'h04);
		chk("abandon", 8'h09, fall - rise);
	endtask

	task automatic end_sim();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_route();
		t_connect();
		t_edge();
		t_capture();
		end_sim();
	end

	// Whole run is well under 1000 cycles
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
endmodule // test_sync_input_timer_routing
